// [rtl/t16c_core.sv]
// t16c_core: 16-bit timer/counter with shared high-byte holding register
// assumes an AXI4-Lite master with byte-wide registers in the low lane
// Functional notes
// - bottom indication when count is zero
// - max indication when count is all ones
// - top chosen by mode: fixed, compare, capture
// - one shared 8-bit high-byte holding register
// - low-byte write loads held high byte together
// - counter and capture low-byte reads copy high byte to holding
// - compare reads bypass the holding register
// - counter high location maps to holding register
// - three-bit clock select in control B
// - select zero stops ticks, count holds
// - each tick clears, increments or decrements
// - each count step changes value by one
// - clear sets all counter bits zero
// - counter accessible whether ticking or not
// - cpu write beats clear and count
// - four-bit mode split across control A, B
// - overflow flag set per mode, usable interrupt
// - external pin edges, rise 7, fall 6
`timescale 1ns/1ns
`default_nettype none
module t16c_core
	import t16c_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic ext_clk_pin,
	output logic [15:0] timer_count_value,
	output logic at_bottom,
	output logic at_max,
	output logic at_top,
	output logic overflow_flag
);
	logic [7:0] control_reg_a, control_reg_b, count_upper_byte;
	logic [15:0] first_compare_value, second_compare_value, capture_value, top_value;
	logic count_up, timer_tick;
	logic [2:0] clock_select_field;
	logic [3:0] waveform_mode_field;
	t16c_seq_e seq;
	t16c_tops_e top_src;

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data held separately, either order
	logic [ADDR_W-1:0] aw_addr_q, wr_word;
	logic [7:0] w_byte_q;
	logic aw_full, w_lane_q, w_full, wr_go, wr_en, wr_hit;
	assign awready = !aw_full;
	assign wready = !w_full;
	assign wr_go = aw_full && w_full && !bvalid;
	assign wr_en = wr_go && w_lane_q;
	assign wr_word = {aw_addr_q[ADDR_W-1:2], 2'b00};
	always_comb begin
		unique case (wr_word)
			CTRL_A_OFS, CTRL_B_OFS, CNT_LO_OFS, CNT_HI_OFS, CMPA_LO_OFS, CMPA_HI_OFS,
			CMPB_LO_OFS, CMPB_HI_OFS, CAP_LO_OFS, CAP_HI_OFS, FLAG_OFS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			aw_addr_q <= '0;
		end else if (awvalid && awready) begin
			aw_full <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (wr_go) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full <= 1'b0;
			w_byte_q <= BYTE_ZERO;
			w_lane_q <= 1'b0;
		end else if (wvalid && wready) begin
			w_full <= 1'b1;
			w_byte_q <= wdata[7:0];
			w_lane_q <= wstrb[0];
		end else if (wr_go) begin
			w_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	logic wr_ctrl_a, wr_ctrl_b, wr_cnt_lo, wr_any_hi, wr_cmpa_lo, wr_cmpb_lo, wr_cap_lo, wr_flag;
	assign wr_ctrl_a = wr_en && wr_word == CTRL_A_OFS;
	assign wr_ctrl_b = wr_en && wr_word == CTRL_B_OFS;
	assign wr_cnt_lo = wr_en && wr_word == CNT_LO_OFS;
	assign wr_cmpa_lo = wr_en && wr_word == CMPA_LO_OFS;
	assign wr_cmpb_lo = wr_en && wr_word == CMPB_LO_OFS;
	assign wr_cap_lo = wr_en && wr_word == CAP_LO_OFS;
	assign wr_flag = wr_en && wr_word == FLAG_OFS;
	// every high-byte location lands in the one holding register
	assign wr_any_hi = wr_en && (wr_word == CNT_HI_OFS || wr_word == CMPA_HI_OFS ||
		wr_word == CMPB_HI_OFS || wr_word == CAP_HI_OFS);

	////////////////////////////////////////////////////////////////////////
	// read channel: one word at a time, answer the cycle after arvalid
	logic [ADDR_W-1:0] rd_word;
	logic [7:0] rd_byte;
	logic ar_fire, rd_hit, rd_cnt_lo, rd_cap_lo;
	assign arready = !rvalid;
	assign ar_fire = arvalid && arready;
	assign rd_word = {araddr[ADDR_W-1:2], 2'b00};
	assign rd_cnt_lo = ar_fire && rd_word == CNT_LO_OFS;
	assign rd_cap_lo = ar_fire && rd_word == CAP_LO_OFS;
	always_comb begin
		rd_hit = 1'b1;
		unique case (rd_word)
			CTRL_A_OFS: rd_byte = control_reg_a;
			CTRL_B_OFS: rd_byte = control_reg_b;
			CNT_LO_OFS: rd_byte = timer_count_value[7:0];
			CNT_HI_OFS: rd_byte = count_upper_byte;
			CMPA_LO_OFS: rd_byte = first_compare_value[7:0];
			CMPA_HI_OFS: rd_byte = first_compare_value[15:8];
			CMPB_LO_OFS: rd_byte = second_compare_value[7:0];
			CMPB_HI_OFS: rd_byte = second_compare_value[15:8];
			CAP_LO_OFS: rd_byte = capture_value[7:0];
			CAP_HI_OFS: rd_byte = count_upper_byte;
			FLAG_OFS: rd_byte = {7'h00, overflow_flag};
			default: begin
				rd_byte = BYTE_ZERO;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (ar_fire) begin
			rvalid <= 1'b1;
			rdata <= {24'h000000, rd_byte};
			rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control and holding registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_reg_a <= CTRL_RST;
			control_reg_b <= CTRL_RST;
		end else begin
			if (wr_ctrl_a)
				control_reg_a <= w_byte_q;
			if (wr_ctrl_b)
				control_reg_b <= w_byte_q;
		end
	end

	assign clock_select_field = control_reg_b[CS_MSB:CS_LSB];
	assign waveform_mode_field = {control_reg_b[WGM_B_MSB:WGM_B_LSB],
		control_reg_a[WGM_A_MSB:WGM_A_LSB]};

	// a high-byte write in the same cycle as a low read wins the holding register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			count_upper_byte <= BYTE_ZERO;
		else if (wr_any_hi)
			count_upper_byte <= w_byte_q;
		else if (rd_cnt_lo)
			count_upper_byte <= timer_count_value[15:8];
		else if (rd_cap_lo)
			count_upper_byte <= capture_value[15:8];
	end

	// compare and capture load both bytes at once on the low write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_compare_value <= WORD_ZERO;
			second_compare_value <= WORD_ZERO;
			capture_value <= WORD_ZERO;
		end else begin
			if (wr_cmpa_lo)
				first_compare_value <= {count_upper_byte, w_byte_q};
			if (wr_cmpb_lo)
				second_compare_value <= {count_upper_byte, w_byte_q};
			if (wr_cap_lo)
				capture_value <= {count_upper_byte, w_byte_q};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode decode: sequence kind and top source
	always_comb begin
		unique case (waveform_mode_field)
			4'h1: begin seq = SEQ_DUAL; top_src = TOPS_8; end
			4'h2: begin seq = SEQ_DUAL; top_src = TOPS_9; end
			4'h3: begin seq = SEQ_DUAL; top_src = TOPS_10; end
			4'h4: begin seq = SEQ_CTC; top_src = TOPS_CMPA; end
			4'h5: begin seq = SEQ_FAST; top_src = TOPS_8; end
			4'h6: begin seq = SEQ_FAST; top_src = TOPS_9; end
			4'h7: begin seq = SEQ_FAST; top_src = TOPS_10; end
			4'h8, 4'ha: begin seq = SEQ_DUAL; top_src = TOPS_CAP; end
			4'h9, 4'hb: begin seq = SEQ_DUAL; top_src = TOPS_CMPA; end
			4'hc: begin seq = SEQ_CTC; top_src = TOPS_CAP; end
			4'he: begin seq = SEQ_FAST; top_src = TOPS_CAP; end
			4'hf: begin seq = SEQ_FAST; top_src = TOPS_CMPA; end
			default: begin seq = SEQ_NORMAL; top_src = TOPS_MAX; end
		endcase
	end

	always_comb begin
		unique case (top_src)
			TOPS_MAX: top_value = CNT_MAX;
			TOPS_8: top_value = TOP_8BIT;
			TOPS_9: top_value = TOP_9BIT;
			TOPS_10: top_value = TOP_10BIT;
			TOPS_CMPA: top_value = first_compare_value;
			TOPS_CAP: top_value = capture_value;
		endcase
	end

	assign at_bottom = timer_count_value == CNT_BOTTOM;
	assign at_max = timer_count_value == CNT_MAX;
	assign at_top = timer_count_value == top_value;
	////////////////////////////////////////////////////////////////////////
	// counter unit
	t16c_tick_gen u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.clock_select_field(clock_select_field),
		.ext_clk_pin(ext_clk_pin),
		.timer_tick(timer_tick)
	);

	logic step, do_clear, go_up, next_up, ovf_event;
	// a counter low write swallows the tick entirely, including its overflow
	assign step = timer_tick && !wr_cnt_lo;

	always_comb begin
		do_clear = 1'b0;
		go_up = 1'b1;
		next_up = count_up;
		ovf_event = 1'b0;
		unique case (seq)
			SEQ_NORMAL: ovf_event = at_max;
			SEQ_CTC: begin
				do_clear = at_top;
				ovf_event = at_max;
			end
			SEQ_FAST: begin
				do_clear = at_top;
				ovf_event = at_top;
			end
			SEQ_DUAL: begin
				// turn at either end; a top below the count keeps going up to wrap
				if (count_up && at_top)
					next_up = 1'b0;
				else if (!count_up && at_bottom)
					next_up = 1'b1;
				go_up = next_up;
				ovf_event = at_bottom && !count_up;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			timer_count_value <= WORD_ZERO;
		else if (wr_cnt_lo)
			timer_count_value <= {count_upper_byte, w_byte_q};
		else if (step && do_clear)
			timer_count_value <= WORD_ZERO;
		else if (step && go_up)
			timer_count_value <= timer_count_value + CNT_ONE;
		else if (step)
			timer_count_value <= timer_count_value - CNT_ONE;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			count_up <= 1'b1;
		else if (seq != SEQ_DUAL)
			count_up <= 1'b1;
		else if (step)
			count_up <= next_up;
	end
	// set beats a write-one clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			overflow_flag <= 1'b0;
		else if (step && ovf_event)
			overflow_flag <= 1'b1;
		else if (wr_flag && w_byte_q[OVF_BIT])
			overflow_flag <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_cnt_load;
		wr_cnt_lo;
	endsequence
	sequence s_plain_step;
		step && !do_clear;
	endsequence
	bottom_seen_a: assert property (timer_count_value == CNT_BOTTOM |-> at_bottom)
		else $error("bottom indication missing at zero");
	max_seen_a: assert property (at_max |-> timer_count_value == CNT_MAX)
		else $error("max indication without all ones");
	fixed_top_a: assert property (waveform_mode_field == 4'h5 |-> top_value == TOP_8BIT)
		else $error("fixed top wrong in 8-bit fast mode");
	cpu_load_a: assert property (s_cnt_load |=> timer_count_value ==
		{$past(count_upper_byte), $past(w_byte_q)})
		else $error("counter load lost or wrong");
	lo_read_copy_a: assert property (rd_cnt_lo && !wr_any_hi |=>
		count_upper_byte == $past(timer_count_value[15:8]))
		else $error("holding register not refreshed on low read");
	cmp_read_keep_a: assert property (ar_fire && rd_word == CMPA_HI_OFS && !wr_any_hi |=>
		$stable(count_upper_byte) ##0 rdata[7:0] == first_compare_value[15:8])
		else $error("compare read disturbed holding register");
	stop_hold_a: assert property (clock_select_field == CS_STOP && !wr_cnt_lo [*2] |=>
		$stable(timer_count_value))
		else $error("counter moved while stopped");
	step_one_a: assert property (s_plain_step |=> (timer_count_value - $past(timer_count_value)
		== CNT_ONE) || ($past(timer_count_value) - timer_count_value == CNT_ONE))
		else $error("count step not exactly one");
	clear_zero_a: assert property (step && do_clear |=> timer_count_value == CNT_BOTTOM)
		else $error("clear left bits set");
	ovf_set_a: assert property (step && ovf_event |=> overflow_flag [*2]
		or (overflow_flag ##1 !overflow_flag))
		else $error("overflow flag not set");
	resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
endmodule : t16c_core
`default_nettype wire

// [rtl/t16c_pkg.sv]
// t16c_pkg: shared constants and types of the 16-bit timer/counter core
// assumes a 32-bit AXI4-Lite register bus with byte data in the low lane
package t16c_pkg;

	////////////////////////////////////////////////////////////////////////
	// bus geometry and answers
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// register byte addresses
	localparam logic [ADDR_W-1:0] CTRL_A_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] CTRL_B_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] CNT_LO_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] CNT_HI_OFS = 8'h0c;
	localparam logic [ADDR_W-1:0] CMPA_LO_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] CMPA_HI_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] CMPB_LO_OFS = 8'h18;
	localparam logic [ADDR_W-1:0] CMPB_HI_OFS = 8'h1c;
	localparam logic [ADDR_W-1:0] CAP_LO_OFS = 8'h20;
	localparam logic [ADDR_W-1:0] CAP_HI_OFS = 8'h24;
	localparam logic [ADDR_W-1:0] FLAG_OFS = 8'h28;

	////////////////////////////////////////////////////////////////////////
	// field positions and reset values
	localparam int CS_MSB = 2;
	localparam int CS_LSB = 0;
	localparam int WGM_A_MSB = 1;
	localparam int WGM_A_LSB = 0;
	localparam int WGM_B_MSB = 4;
	localparam int WGM_B_LSB = 3;
	localparam int OVF_BIT = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// count sequence landmarks
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [15:0] CNT_ONE = 16'h0001;

	////////////////////////////////////////////////////////////////////////
	// clock select codes and prescaler masks
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRE_W = 10;
	localparam logic [PRE_W-1:0] PRE_MASK8 = 10'h007;
	localparam logic [PRE_W-1:0] PRE_MASK64 = 10'h03f;
	localparam logic [PRE_W-1:0] PRE_MASK256 = 10'h0ff;
	localparam logic [PRE_W-1:0] PRE_MASK1024 = 10'h3ff;
	localparam logic [PRE_W-1:0] PRE_ONE = 10'h001;

	////////////////////////////////////////////////////////////////////////
	// count sequence kinds and top sources
	typedef enum {SEQ_NORMAL, SEQ_CTC, SEQ_FAST, SEQ_DUAL} t16c_seq_e;
	typedef enum {TOPS_MAX, TOPS_8, TOPS_9, TOPS_10, TOPS_CMPA, TOPS_CAP} t16c_tops_e;

endpackage : t16c_pkg

// [rtl/t16c_tick_gen.sv]
// t16c_tick_gen: timer tick from the prescaler or the external clock pin
// assumes the pin is asynchronous to aclk and slower than aclk / 4
`timescale 1ns/1ns
`default_nettype none
module t16c_tick_gen
	import t16c_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] clock_select_field,
	input wire logic ext_clk_pin,
	output logic timer_tick
);

	logic [PRE_W-1:0] pre;
	logic [2:0] pin_sync;
	logic pin_level;
	logic pin_rise;
	logic pin_fall;
	logic next_tick;

	////////////////////////////////////////////////////////////////////////
	// free-running prescaler
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pre <= '0;
		else
			pre <= pre + PRE_ONE;
	end

	// stage 0 feeds stage 1 only; a change counts when stages 1 and 2 agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_sync <= 3'h0;
			pin_level <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], ext_clk_pin};
			if (pin_sync[1] == pin_sync[2])
				pin_level <= pin_sync[2];
		end
	end

	assign pin_rise = (pin_sync[1] == pin_sync[2]) && pin_sync[2] && !pin_level;
	assign pin_fall = (pin_sync[1] == pin_sync[2]) && !pin_sync[2] && pin_level;

	always_comb begin
		unique case (clock_select_field)
			CS_STOP: next_tick = 1'b0;
			CS_DIV1: next_tick = 1'b1;
			CS_DIV8: next_tick = (pre & PRE_MASK8) == PRE_MASK8;
			CS_DIV64: next_tick = (pre & PRE_MASK64) == PRE_MASK64;
			CS_DIV256: next_tick = (pre & PRE_MASK256) == PRE_MASK256;
			CS_DIV1024: next_tick = (pre & PRE_MASK1024) == PRE_MASK1024;
			CS_EXT_FALL: next_tick = pin_fall;
			CS_EXT_RISE: next_tick = pin_rise;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			timer_tick <= 1'b0;
		else
			timer_tick <= next_tick;
	end

endmodule : t16c_tick_gen
`default_nettype wire

// [bench/t16c_cpu_model.sv]
// t16c_cpu_model: axi4-lite master standing in for the cpu on the byte bus
// assumes one caller at a time and the bench watchdog to end a hung wait
`timescale 1ns/1ns
`default_nettype none
module t16c_cpu_model
	import t16c_pkg::*;
(
	input wire logic aclk,
	output logic [ADDR_W-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [DATA_W-1:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [ADDR_W-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// released payloads are inverted so stale values never look valid
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~{24'h000000, d};
			end
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
			output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
endmodule : t16c_cpu_model
`default_nettype wire

// [bench/tb_top.sv]
// tb_top: self-checking bench of the timer/counter core
// assumes the cpu model drives the register bus; the bench drives the count pin
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import t16c_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ext_clk_pin = 1'b0;
	logic [ADDR_W-1:0] awaddr;
	logic [ADDR_W-1:0] araddr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [15:0] cnt;
	logic at_bottom, at_max, at_top, overflow_flag;
	int mismatches = 0;
	int n_compared = 0;
	always #2 aclk = ~aclk;
	t16c_core uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ext_clk_pin(ext_clk_pin), .timer_count_value(cnt), .at_bottom(at_bottom),
		.at_max(at_max), .at_top(at_top), .overflow_flag(overflow_flag));
	t16c_cpu_model cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic chk_flag(input logic got, input string msg);
		n_compared++;
		if (got !== 1'b1) begin
			mismatches++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk_flag
	task automatic w(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [1:0] r;
		cpu.wr(a, d, r);
	endtask : w
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		logic [DATA_W-1:0] x;
		logic [1:0] r;
		cpu.rd(a, x, r);
		d = x[7:0];
	endtask : rd
	task automatic set_cnt(input logic [15:0] v);
		w(CNT_HI_OFS, v[15:8]);
		w(CNT_LO_OFS, v[7:0]);
	endtask : set_cnt
	task automatic idle(input int n);
		repeat (n) @(negedge aclk);
	endtask : idle
	task automatic finish_test();
		if (mismatches == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		idle(1);
		chk(cnt, WORD_ZERO, "count after reset");
		chk_flag(at_bottom, "bottom after reset");
		chk_flag(!at_max && !overflow_flag, "max or flag after reset");
	endtask : t_reset
	task automatic t_access();
		logic [7:0] b;
		w(CTRL_B_OFS, 8'h00);
		set_cnt(16'h1234);
		idle(20);
		chk(cnt, 16'h1234, "stopped count");
		rd(CNT_LO_OFS, b);
		chk({8'h00, b}, 16'h0034, "count low");
		w(CMPA_HI_OFS, 8'hab);
		w(CMPA_LO_OFS, 8'hcd);
		rd(CNT_LO_OFS, b);
		rd(CMPA_HI_OFS, b);
		chk({8'h00, b}, 16'h00ab, "cmpa high");
		rd(CMPA_LO_OFS, b);
		chk({8'h00, b}, 16'h00cd, "cmpa low");
		rd(CNT_HI_OFS, b);
		chk({8'h00, b}, 16'h0012, "held high byte");
		w(CNT_HI_OFS, 8'h55);
		chk(cnt, 16'h1234, "high write touched count");
		w(CNT_LO_OFS, 8'h01);
		w(CMPB_LO_OFS, 8'h02);
		chk(cnt, 16'h5501, "shared high byte count");
		rd(CMPB_HI_OFS, b);
		chk({8'h00, b}, 16'h0055, "shared high byte cmpb");
	endtask : t_access
	task automatic t_count_up();
		logic [15:0] prev;
		logic saw_max = 1'b0;
		logic saw_bot = 1'b0;
		set_cnt(16'hfff0);
		w(CTRL_A_OFS, 8'h00);
		w(FLAG_OFS, 8'h01);
		w(CTRL_B_OFS, {5'h00, CS_DIV1});
		idle(2);
		repeat (24) begin
			prev = cnt;
			idle(1);
			chk(cnt, prev + CNT_ONE, "step up");
			if (cnt === CNT_MAX) saw_max |= at_max;
			if (cnt === CNT_BOTTOM) saw_bot |= at_bottom;
		end
		chk_flag(saw_max, "max indication");
		chk_flag(saw_bot, "bottom indication");
		chk_flag(overflow_flag, "overflow at wrap");
		set_cnt(16'h0100);
		chk_flag(cnt - 16'h0100 < 16'h0004, "write while counting");
		w(CTRL_B_OFS, 8'h00);
		// the tick launched under the old select still lands after the write
		idle(2);
		prev = cnt;
		idle(10);
		chk(cnt, prev, "hold when stopped");
		w(FLAG_OFS, 8'h01);
		chk_flag(!overflow_flag, "flag clear");
	endtask : t_count_up
	task automatic t_fast();
		logic [15:0] prev;
		logic saw_top = 1'b0;
		set_cnt(16'h00f0);
		w(CTRL_A_OFS, 8'h01);
		w(CTRL_B_OFS, 8'h09);
		repeat (40) begin
			prev = cnt;
			idle(1);
			chk_flag(cnt <= TOP_8BIT, "above fixed top");
			if (prev === TOP_8BIT) chk(cnt, WORD_ZERO, "clear at top");
			if (cnt === TOP_8BIT) saw_top |= at_top;
		end
		chk_flag(saw_top, "top indication");
		chk_flag(overflow_flag, "overflow at top");
		w(CTRL_B_OFS, 8'h00);
		w(FLAG_OFS, 8'h01);
	endtask : t_fast
	task automatic t_dual();
		logic [15:0] prev;
		logic turned = 1'b0;
		logic saw_down = 1'b0;
		set_cnt(16'h00f8);
		w(CTRL_A_OFS, 8'h01);
		w(CTRL_B_OFS, 8'h01);
		repeat (30) begin
			prev = cnt;
			idle(1);
			chk_flag(cnt - prev < 16'h0002 || prev - cnt == CNT_ONE, "step size");
			if (cnt === TOP_8BIT) turned = 1'b1;
			if (turned && cnt < TOP_8BIT) saw_down = 1'b1;
		end
		chk_flag(saw_down, "count down after top");
		w(CTRL_B_OFS, 8'h00);
		w(CTRL_A_OFS, 8'h00);
	endtask : t_dual
	task automatic t_ctc();
		logic [7:0] b;
		logic [15:0] prev;
		logic saw_top = 1'b0;
		w(CAP_HI_OFS, 8'h2a);
		w(CAP_LO_OFS, 8'h5c);
		w(CNT_HI_OFS, 8'h00);
		w(CMPA_LO_OFS, 8'h10);
		rd(CAP_LO_OFS, b);
		chk({8'h00, b}, 16'h005c, "capture low");
		rd(CAP_HI_OFS, b);
		chk({8'h00, b}, 16'h002a, "capture high via holding");
		set_cnt(16'h0008);
		w(FLAG_OFS, 8'h01);
		w(CTRL_B_OFS, 8'h09);
		repeat (30) begin
			prev = cnt;
			idle(1);
			chk_flag(cnt <= 16'h0010, "above compare top");
			if (prev === 16'h0010) chk(cnt, WORD_ZERO, "clear at compare top");
			if (cnt === 16'h0010) saw_top |= at_top;
		end
		chk_flag(saw_top, "compare top indication");
		chk_flag(!overflow_flag, "no overflow below max");
		w(CTRL_B_OFS, 8'h00);
	endtask : t_ctc
	task automatic t_ext();
		logic [2:0] sel [2] = '{CS_EXT_RISE, CS_EXT_FALL};
		set_cnt(WORD_ZERO);
		for (int i = 0; i < 2; i++) begin
			w(CTRL_B_OFS, {5'h00, sel[i]});
			repeat (3) begin
				@(posedge aclk);
				ext_clk_pin <= 1'b1;
				idle(8);
				@(posedge aclk);
				ext_clk_pin <= 1'b0;
				idle(8);
			end
			idle(8);
			chk(cnt, 16'(3 * (i + 1)), "pin edges counted");
		end
		w(CTRL_B_OFS, 8'h00);
	endtask : t_ext
	task automatic t_prescale();
		logic [2:0] sel [4] = '{CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
		int div [4] = '{8, 64, 256, 1024};
		for (int i = 0; i < 4; i++) begin
			set_cnt(WORD_ZERO);
			w(CTRL_B_OFS, {5'h00, sel[i]});
			idle(div[i] * 4);
			w(CTRL_B_OFS, 8'h00);
			chk_flag(cnt >= 16'h0003 && cnt <= 16'h0005, "prescaled tick rate");
		end
	endtask : t_prescale
	task automatic t_unmapped();
		logic [DATA_W-1:0] x;
		logic [1:0] r;
		cpu.rd(8'h3c, x, r);
		chk({14'h0000, r}, {14'h0000, RESP_SLVERR}, "unmapped read resp");
		chk(x[15:0], WORD_ZERO, "unmapped read data");
		cpu.wr(8'h3c, 8'hff, r);
		chk({14'h0000, r}, {14'h0000, RESP_SLVERR}, "unmapped write resp");
	endtask : t_unmapped
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_access();
		t_count_up();
		t_fast();
		t_dual();
		t_ctc();
		t_ext();
		t_prescale();
		t_unmapped();
		finish_test();
	end
	// full run is near 6000 cycles; the margin covers slow bus answers
	initial begin
		#100000;
		mismatches++;
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
